// ---- verilog/lbbp_pkg.sv ----
// Package with register map, field layout, reset values and types of the LED PWM block.
package lbbp_pkg;

   // Register byte offsets.
   localparam logic [7:0] ADDR_CFG    = 8'h00;
   localparam logic [7:0] ADDR_LIMITS = 8'h04;
   localparam logic [7:0] ADDR_DELAY  = 8'h08;
   localparam logic [7:0] ADDR_STEP   = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // Configuration register field positions.
   localparam int CFG_CTRL_LSB   = 0;
   localparam int CFG_CLKSRC_BIT = 2;
   localparam int CFG_RESET_BIT  = 7;
   localparam int CFG_RELOAD_LSB = 8;
   localparam int CFG_POL_BIT    = 16;

   // Limits, delay and step register field positions.
   localparam int LIM_MIN_LSB       = 0;
   localparam int LIM_MAX_LSB       = 8;
   localparam int DLY_PRESCALE_LSB  = 0;
   localparam int DLY_RAMP_LSB      = 12;
   localparam int STEP_SIZE_LSB     = 0;
   localparam int STEP_HOLD_MAX_LSB = 8;
   localparam int STEP_HOLD_MIN_LSB = 16;

   // Mode control encodings.
   localparam logic [1:0] CTRL_OFF     = 2'h0;
   localparam logic [1:0] CTRL_BREATHE = 2'h1;
   localparam logic [1:0] CTRL_BLINK   = 2'h2;
   localparam logic [1:0] CTRL_ON      = 2'h3;

   // Reset values and the full duty code.
   localparam logic [7:0]  WDT_RELOAD_RST = 8'h14;
   localparam logic [7:0]  DUTY_FULL      = 8'hFF;
   localparam logic [7:0]  MAX_RST        = 8'hFF;
   localparam logic [7:0]  STEP_RST       = 8'h01;
   localparam logic [11:0] PRESCALE_RST   = 12'h000;
   localparam logic [11:0] RAMP_RST       = 12'h000;
   localparam logic [7:0]  HOLD_RST       = 8'h00;

   typedef enum logic [1:0] {
      LBBP_RISE,
      LBBP_HOLD_MAX,
      LBBP_FALL,
      LBBP_HOLD_MIN
   } lbbp_breath_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } lbbp_bus_t;

   typedef struct packed {
      logic        polarity;
      logic [7:0]  watchdog_reload;
      logic        clk_src;
      logic [1:0]  control;
   } lbbp_cfg_t;

endpackage

// ---- verilog/lbbp_prescaler.sv ----
// Prescaler that pulses once every (limit plus one) input ticks.
`timescale 1ns/1ps
module lbbp_prescaler
   import lbbp_pkg::*;
#(
   parameter int WIDTH = 12
) (
   // Clock, reset and enable.
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             ce,
   // Control.
   input  wire logic             clear,
   input  wire logic             tick,
   input  wire logic [WIDTH-1:0] limit,
   // Result.
   output logic                  expire
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
   } lbbp_presc_st_t;

   lbbp_presc_st_t st;
   lbbp_presc_st_t next_st;

   always_comb begin
      next_st = st;
      if (clear) begin
         next_st.count = '0;
      end else if (tick) begin
         if (st.count >= limit) begin
            next_st.count = '0;
         end else begin
            next_st.count = st.count + WIDTH'(1);
         end
      end
   end

   // The pulse is combinational so the period counter steps in the same cycle as the tick.
   assign expire = !clear && tick && (st.count >= limit);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

endmodule

// ---- verilog/lbbp_pwm.sv ----
// LED blink, breathe and general purpose PWM with watchdog and register port.
// Notes on behaviour
// R1: After reset the pin is active high: high when fully on, low when off.
// R2: Polarity bit set to one inverts the pin level.
// R3: Watchdog timeout interrupt is exactly one main clock cycle long.
// R4: Control 00 off, 01 breathe, 10 blink or PWM by clock select, 11 on.
// R5: General purpose PWM keeps requesting the main clock even under sleep.
// R6: Slow clock modes keep running while the main clock is stopped.
// R7: Power control asserts sleep request to every instance before deep sleep.
// R8: Breathing timing comes from the 32.768 kHz tick only.
// R9: In blinking the duty equals the programmed minimum, never ramped.
// R10: Blinking period counter is an 8-bit up counter stepped by prescaler expiry.
// R11: Blinking counter width is always 8 bits.
// R12: Duty 00h keeps output off, FFh keeps it fully on.
// R13: Blink prescale is the low delay field, duty the minimum field.
// R14: Blink rate is slow clock over prescale plus one over 256.
// R15: Prescale range gives blink rates from 128 Hz down to 0.03125 Hz.
// R16: Hold times at maximum and minimum brightness are set independently.
// R17: Output is on while the period counter is below the duty.
// R18: Breathing ramps up to max, holds, ramps down to min, holds, repeats.
// R19: Watchdog reloads on configuration or limits write; resets to 14h.
// R20: Nonzero watchdog steps down per 5 Hz tick; at zero interrupt, force on.
// R21: Reset clears counters and returns every field to its default.
// R22: Prescaler counts slow ticks, advancing counter every prescale plus one ticks.
`timescale 1ns/1ps
module lbbp_pwm
   import lbbp_pkg::*;
#(
   parameter int PRESCALE_W = 12
) (
   // Clock, reset and enable.
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        ce,
   // Time base ticks, one clock cycle each.
   input  wire logic        slow_tick,
   input  wire logic        wdt_tick,
   // Register port.
   input  wire lbbp_bus_t   bus,
   output logic [31:0]      rdata,
   // Power control.
   input  wire logic        sleep_req,
   output logic             main_clk_req,
   // Pin and event.
   output logic             pwm_out,
   output logic             pwm_watchdog_timeout
);

   typedef struct packed {
      lbbp_cfg_t               cfg;
      logic [7:0]              lim_min;
      logic [7:0]              lim_max;
      logic [PRESCALE_W-1:0]   low_delay_prescale;
      logic [11:0]             ramp_delay;
      logic [7:0]              step;
      logic [7:0]              hold_max;
      logic [7:0]              hold_min;
      logic [7:0]              duty;
      logic [7:0]              period_counter;
      logic [11:0]             ramp_cnt;
      logic [7:0]              hold_cnt;
      lbbp_breath_t            bstate;
      logic [7:0]              wdt;
      logic                    irq;
      logic                    pin;
      logic [31:0]             rdata;
   } lbbp_state_t;

   function automatic lbbp_state_t rst_state();
      lbbp_state_t s;
      s = '0;
      s.cfg.watchdog_reload = WDT_RELOAD_RST;
      s.cfg.control         = CTRL_OFF;
      s.lim_max             = MAX_RST;
      s.low_delay_prescale  = PRESCALE_W'(PRESCALE_RST);
      s.ramp_delay          = RAMP_RST;
      s.step                = STEP_RST;
      s.hold_max            = HOLD_RST;
      s.hold_min            = HOLD_RST;
      s.wdt                 = WDT_RELOAD_RST;
      s.bstate              = LBBP_RISE;
      return s;
   endfunction

   // Raw level before polarity, from the mode, the counter and the duty.
   function automatic logic duty_level(logic [1:0] ctrl, logic [7:0] cnt, logic [7:0] duty);
      logic lvl;
      lvl = 1'b0;
      case (ctrl)
         CTRL_OFF: lvl = 1'b0;
         CTRL_ON:  lvl = 1'b1;
         default:  lvl = (duty == DUTY_FULL) || (cnt < duty);
      endcase
      return lvl;
   endfunction

   localparam lbbp_state_t ST_RST = rst_state();

   lbbp_state_t st;
   lbbp_state_t next_st;

   logic is_off;
   logic is_breathe;
   logic is_blink;
   logic is_gp;
   logic presc_expire;
   logic period_step;
   logic period_wrap;
   logic ramp_tick;
   logic wdt_expire;
   logic [8:0] duty_sum;
   logic pin_level;
   logic soft_rst;

   assign is_off     = st.cfg.control == CTRL_OFF;
   assign is_breathe = st.cfg.control == CTRL_BREATHE; // R4
   assign is_blink   = (st.cfg.control == CTRL_BLINK) && !st.cfg.clk_src; // R4
   assign is_gp      = (st.cfg.control == CTRL_BLINK) && st.cfg.clk_src; // R4

   // Blinking counts slow ticks; general purpose PWM counts every main clock cycle.
   lbbp_prescaler #(
      .WIDTH (PRESCALE_W)
   ) u_prescaler (
      .clock  (clock),
      .rstn   (rstn),
      .ce     (ce),
      .clear  (!(is_blink || is_gp)),
      .tick   (st.cfg.clk_src ? 1'b1 : slow_tick),
      .limit  (st.low_delay_prescale),
      .expire (presc_expire)
   ); // R13 R15 R22

   assign period_step = ((is_blink || is_gp) && presc_expire) || (is_breathe && slow_tick); // R8 R10
   assign period_wrap = period_step && (st.period_counter == 8'hFF);
   assign ramp_tick   = period_wrap && (st.ramp_cnt >= st.ramp_delay);
   assign wdt_expire  = is_gp && wdt_tick && (st.wdt == 8'h01); // R20
   assign duty_sum    = {1'b0, st.duty} + {1'b0, st.step};
   assign soft_rst    = bus.wr && (bus.addr == ADDR_CFG) && bus.wdata[CFG_RESET_BIT];
   assign pin_level   = duty_level(st.cfg.control, st.period_counter, st.duty)
                        ^ st.cfg.polarity; // R1 R2 R12 R17

   always_comb begin
      next_st     = st;
      next_st.irq = 1'b0;
      // Off holds the period, ramp and hold counters and the duty at zero so a restart begins from a dark, known point.
      if (is_off) begin
         next_st.period_counter = 8'h00;
         next_st.duty           = 8'h00;
         next_st.ramp_cnt       = 12'h000;
         next_st.hold_cnt       = 8'h00;
         next_st.bstate         = LBBP_RISE;
      end else if (period_step) begin
         next_st.period_counter = st.period_counter + 8'h01; // R10 R11 R14
      end
      if (is_blink || is_gp) begin
         next_st.duty = st.lim_min; // R9 R13
      end
      if (is_breathe && period_wrap) begin
         next_st.ramp_cnt = ramp_tick ? 12'h000 : st.ramp_cnt + 12'h001;
      end
      if (is_breathe && ramp_tick) begin
         case (st.bstate)
            LBBP_RISE: begin
               if (duty_sum >= {1'b0, st.lim_max}) begin
                  next_st.duty     = st.lim_max;
                  next_st.hold_cnt = 8'h00;
                  next_st.bstate   = LBBP_HOLD_MAX; // R18
               end else begin
                  next_st.duty = duty_sum[7:0];
               end
            end
            LBBP_HOLD_MAX: begin
               if (st.hold_cnt >= st.hold_max) begin
                  next_st.bstate = LBBP_FALL; // R16 R18
               end else begin
                  next_st.hold_cnt = st.hold_cnt + 8'h01;
               end
            end
            LBBP_FALL: begin
               if ({1'b0, st.duty} <= {1'b0, st.lim_min} + {1'b0, st.step}) begin
                  next_st.duty     = st.lim_min;
                  next_st.hold_cnt = 8'h00;
                  next_st.bstate   = LBBP_HOLD_MIN; // R18
               end else begin
                  next_st.duty = st.duty - st.step;
               end
            end
            LBBP_HOLD_MIN: begin
               if (st.hold_cnt >= st.hold_min) begin
                  next_st.bstate = LBBP_RISE; // R16 R18
               end else begin
                  next_st.hold_cnt = st.hold_cnt + 8'h01;
               end
            end
            default: next_st.bstate = LBBP_RISE;
         endcase
      end
      if (is_gp && wdt_tick && (st.wdt != 8'h00)) begin
         next_st.wdt = st.wdt - 8'h01; // R20
      end
      // Registered pin, inverted when the polarity bit is set.
      next_st.pin = pin_level; // R1 R2 R12 R17
      // Read data stand only in the cycle after the strobe.
      next_st.rdata = 32'h0000_0000;
      if (bus.rd) begin
         case (bus.addr)
            ADDR_CFG:    next_st.rdata = {15'h0000, st.cfg.polarity, st.cfg.watchdog_reload,
                                          5'h00, st.cfg.clk_src, st.cfg.control};
            ADDR_LIMITS: next_st.rdata = {16'h0000, st.lim_max, st.lim_min};
            ADDR_DELAY:  next_st.rdata = {8'h00, st.ramp_delay,
                                          12'(st.low_delay_prescale)};
            ADDR_STEP:   next_st.rdata = {8'h00, st.hold_min, st.hold_max, st.step};
            ADDR_STATUS: next_st.rdata = {5'h00, st.pin, st.bstate, st.wdt,
                                          st.period_counter, st.duty};
            default:     next_st.rdata = 32'h0000_0000;
         endcase
      end
      if (bus.wr) begin
         case (bus.addr)
            ADDR_CFG: begin
               if (bus.wdata[CFG_RESET_BIT]) begin
                  next_st = ST_RST; // R21
               end else begin
                  next_st.cfg.control         = bus.wdata[CFG_CTRL_LSB +: 2];
                  next_st.cfg.clk_src         = bus.wdata[CFG_CLKSRC_BIT];
                  next_st.cfg.watchdog_reload = bus.wdata[CFG_RELOAD_LSB +: 8];
                  next_st.cfg.polarity        = bus.wdata[CFG_POL_BIT];
                  next_st.wdt                 = bus.wdata[CFG_RELOAD_LSB +: 8]; // R19
               end
            end
            ADDR_LIMITS: begin
               next_st.lim_min = bus.wdata[LIM_MIN_LSB +: 8];
               next_st.lim_max = bus.wdata[LIM_MAX_LSB +: 8];
               next_st.wdt     = st.cfg.watchdog_reload; // R19
            end
            ADDR_DELAY: begin
               next_st.low_delay_prescale = bus.wdata[DLY_PRESCALE_LSB +: PRESCALE_W];
               next_st.ramp_delay         = bus.wdata[DLY_RAMP_LSB +: 12];
            end
            ADDR_STEP: begin
               next_st.step     = bus.wdata[STEP_SIZE_LSB +: 8];
               next_st.hold_max = bus.wdata[STEP_HOLD_MAX_LSB +: 8];
               next_st.hold_min = bus.wdata[STEP_HOLD_MIN_LSB +: 8];
            end
            default: next_st.cfg = next_st.cfg;
         endcase
      end
      // Expiry wins over a same-cycle configuration write so the event is never lost.
      if (wdt_expire) begin
         next_st.irq         = 1'b1; // R3
         next_st.cfg.control = CTRL_ON; // R20
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st <= ST_RST; // R21
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign rdata                = st.rdata;
   assign pwm_out              = st.pin;
   // With a frozen enable the pulse could stretch; the enable is expected high in PWM use.
   assign pwm_watchdog_timeout = st.irq;
   // Slow clock modes only need the main clock for register access, so sleep may stop it.
   assign main_clk_req         = is_gp || !sleep_req; // R5 R6 R7

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_expire;
      ce && wdt_expire;
   endsequence

   sequence s_forced_on;
      pwm_watchdog_timeout && (st.cfg.control == CTRL_ON);
   endsequence

   a_irq_one_cycle: assert property (pwm_watchdog_timeout && ce |=> !pwm_watchdog_timeout) // R3
      else $error("watchdog interrupt longer than one cycle");

   a_wdt_force_on: assert property (s_expire |=> s_forced_on) // R20
      else $error("watchdog expiry did not force on and interrupt");

   a_irq_has_cause: assert property (ce && !wdt_expire |=> !pwm_watchdog_timeout) // R3
      else $error("interrupt without watchdog expiry");

   a_wdt_reload: assert property (ce && bus.wr && bus.addr == ADDR_CFG
                                  && !bus.wdata[CFG_RESET_BIT] && !wdt_expire
                                  |=> st.wdt == $past(bus.wdata[15:8])) // R19
      else $error("watchdog not reloaded on configuration write");

   a_gp_clk_req: assert property (is_gp |-> main_clk_req) // R5
      else $error("general purpose PWM dropped main clock request");

   a_blink_duty: assert property (ce && (is_blink || is_gp) && !bus.wr
                                  |=> st.duty == $past(st.lim_min)) // R9
      else $error("blink duty differs from programmed minimum");

   a_blink_hold: assert property (ce && is_blink && !presc_expire && !bus.wr
                                  |=> $stable(st.period_counter)) // R10
      else $error("blink counter moved without prescaler expiry");

   a_breathe_base: assert property (ce && is_breathe && !slow_tick && !bus.wr
                                    |=> $stable(st.period_counter)) // R8
      else $error("breathing counter moved without slow tick");

   // A soft reset forces the pin low at once, so it is left out of the level check.
   a_pin_level: assert property (ce && !soft_rst |=> pwm_out == $past(pin_level)) // R2
      else $error("pin level does not follow duty and polarity");

   a_full_duty_on: assert property (ce && is_blink && st.duty == DUTY_FULL && !bus.wr
                                    && !st.cfg.polarity |=> pwm_out) // R12
      else $error("full duty did not keep the pin high");

   a_off_low: assert property (ce && is_off && !st.cfg.polarity |=> !pwm_out) // R1
      else $error("off mode did not keep the pin low");

   sequence s_hold_max_done;
      ce && is_breathe && ramp_tick && !bus.wr && (st.bstate == LBBP_HOLD_MAX)
      && (st.hold_cnt >= st.hold_max);
   endsequence

   sequence s_rise_step;
      ce && is_breathe && ramp_tick && !bus.wr && (st.bstate == LBBP_RISE)
      && (duty_sum < {1'b0, st.lim_max});
   endsequence

   a_hold_max_end: assert property (s_hold_max_done |=> st.bstate == LBBP_FALL) // R16
      else $error("breathing did not leave the maximum hold");

   a_ramp_rise: assert property (s_rise_step
                                 |=> st.duty == $past(st.duty) + $past(st.step)) // R18
      else $error("breathing rise did not add one step");

   a_blink_step: assert property (ce && is_blink && presc_expire && !bus.wr
                                  |=> st.period_counter == $past(st.period_counter) + 8'h01) // R10
      else $error("blink counter did not step on prescaler expiry");

   a_wdt_step: assert property (ce && is_gp && wdt_tick && (st.wdt > 8'h01) && !bus.wr
                                |=> st.wdt == $past(st.wdt) - 8'h01) // R20
      else $error("watchdog did not count down on its tick");

   a_slow_sleep: assert property (sleep_req && !is_gp |-> !main_clk_req) // R6
      else $error("slow clock mode kept the main clock under sleep");

endmodule

// ---- sim/lbbp_led_load.sv ----
// Behavioural LED load that counts the clock cycles in which the pin lights it.
`timescale 1ns/1ps
module lbbp_led_load (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rstn,
   // Pin from the PWM.
   input  wire logic        pin,
   // Observed light.
   output logic [15:0]      lit_cycles
);
   // The load is active high, and an unknown pin level never counts as lit.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lit_cycles <= 16'h0000;
      end else if (pin === 1'b1) begin
         lit_cycles <= lit_cycles + 16'h0001;
      end
   end
endmodule

// ---- sim/lbbp_pwm_tb_top.sv ----
// Self-checking testbench of the LED blink, breathe and PWM block.
`timescale 1ns/1ps
module lbbp_pwm_tb_top
   import lbbp_pkg::*;
;
   logic        clock     = 1'b0;
   logic        rstn      = 1'b0;
   logic        ce        = 1'b1;
   logic        slow_tick = 1'b0;
   logic        wdt_tick  = 1'b0;
   lbbp_bus_t   bus       = '0;
   logic        sleep_req = 1'b0;
   logic [31:0] rdata;
   logic        main_clk_req;
   logic        pwm_out;
   logic        pwm_watchdog_timeout;
   logic [15:0] lit_cycles;
   logic [31:0] rv;
   int          err_count  = 0;
   int          num_checks = 0;
   int          to_cnt     = 0;
   logic [7:0]  addr_tab [6] = '{ADDR_CFG, ADDR_LIMITS, ADDR_DELAY, ADDR_STEP, ADDR_STATUS,
                                8'h20};
   logic [31:0] rst_tab  [6] = '{32'h0000_1400, 32'h0000_FF00, 32'h0000_0000, 32'h0000_0001,
                                32'h0014_0000, 32'h0000_0000};

   always #25 clock = ~clock;

   always @(posedge clock) begin
      if (pwm_watchdog_timeout === 1'b1) begin
         to_cnt <= to_cnt + 1;
      end
   end

   lbbp_pwm #(.PRESCALE_W(12)) u_dut (
      .clock(clock), .rstn(rstn), .ce(ce), .slow_tick(slow_tick), .wdt_tick(wdt_tick),
      .bus(bus), .rdata(rdata), .sleep_req(sleep_req), .main_clk_req(main_clk_req),
      .pwm_out(pwm_out), .pwm_watchdog_timeout(pwm_watchdog_timeout));

   lbbp_led_load u_load (.clock(clock), .rstn(rstn), .pin(pwm_out), .lit_cycles(lit_cycles));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_pin(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge clock);
      bus.wr    <= 1'b0;
   endtask

   // Read data is only valid in the cycle after the strobe, so it is taken just past that edge.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clock);
      bus.rd   <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic pulse(input bit wdt, input int n);
      repeat (n) begin
         @(posedge clock);
         if (wdt) wdt_tick <= 1'b1;
         else slow_tick <= 1'b1;
         @(posedge clock);
         wdt_tick  <= 1'b0;
         slow_tick <= 1'b0;
      end
   endtask

   task automatic settle;
      repeat (3) @(posedge clock);
      #1;
   endtask

   initial begin
      repeat (90000) @(posedge clock);
      $display("Run limit reached");
      err_count++;
      print_verdict();
   end

   initial begin
      logic [11:0] p;
      logic [7:0]  d;
      logic [7:0]  e;
      logic [15:0] l0;
      int          n;
      int          st;
      int          prev;
      int          seen;
      int          t0;
      void'($urandom(32'h1ed8_8004));
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(addr_tab[i], rv);
         chk("reset value", rst_tab[i], rv);
      end
      // Every mode code with both clock selects, while sleep is requested.
      sleep_req <= 1'b1;
      for (int m = 0; m < 8; m++) begin
         wr(ADDR_CFG, 32'(m));
         settle();
         chk_pin("main clock request", m == 6, main_clk_req);
         chk_pin("mode pin", m[1:0] == 2'h3, pwm_out);
      end
      sleep_req <= 1'b0;
      settle();
      chk_pin("main clock request awake", 1'b1, main_clk_req);
      wr(ADDR_CFG, 32'h0001_0000);
      settle();
      chk_pin("inverted off", 1'b1, pwm_out);
      wr(ADDR_CFG, 32'h0001_0003);
      settle();
      chk_pin("inverted on", 1'b0, pwm_out);
      wr(ADDR_CFG, 32'h0000_0003);
      settle();
      l0 = lit_cycles;
      repeat (20) @(posedge clock);
      #1;
      chk("load lit cycles", 32'd20, {16'h0000, lit_cycles - l0});
      // Writes while the clock enable is low are lost.
      @(posedge clock);
      ce <= 1'b0;
      wr(ADDR_LIMITS, 32'h0000_1234);
      @(posedge clock);
      ce <= 1'b1;
      rd(ADDR_LIMITS, rv);
      chk("limits after disabled write", 32'h0000_FF00, rv);
      wr(ADDR_LIMITS, 32'h0000_1234);
      wr(ADDR_CFG, 32'h0000_0080);
      rd(ADDR_LIMITS, rv);
      chk("limits after soft reset", 32'h0000_FF00, rv);
      for (int i = 0; i < 8; i++) begin
         p = 12'($urandom_range(3));
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
         n = $urandom_range(700);
         wr(ADDR_CFG, 32'h0000_0080);
         wr(ADDR_DELAY, {20'h0_0000, p});
         wr(ADDR_LIMITS, {16'h0000, 8'hFF, d});
         wr(ADDR_CFG, 32'h0000_0002);
         pulse(1'b0, n);
         settle();
         rd(ADDR_STATUS, rv);
         e = 8'(n / (p + 1));
         chk("blink duty", {24'h00_0000, d}, {24'h00_0000, rv[7:0]});
         chk("blink counter", {24'h00_0000, e}, {24'h00_0000, rv[15:8]});
         chk_pin("blink pin", d == 8'hFF || e < d, pwm_out);
      end
      // Slowest prescale: the counter steps once per 4096 slow ticks.
      wr(ADDR_CFG, 32'h0000_0080);
      wr(ADDR_DELAY, 32'h0000_0FFF);
      rd(ADDR_DELAY, rv);
      chk("prescale range", 32'h0000_0FFF, rv);
      wr(ADDR_CFG, 32'h0000_0002);
      pulse(1'b0, 4095);
      settle();
      rd(ADDR_STATUS, rv);
      chk("slowest blink hold", 32'h0000_0000, {24'h00_0000, rv[15:8]});
      pulse(1'b0, 1);
      settle();
      rd(ADDR_STATUS, rv);
      chk("slowest blink step", 32'h0000_0001, {24'h00_0000, rv[15:8]});
      // Watchdog in general purpose mode with a short reload.
      wr(ADDR_CFG, 32'h0000_0080);
      wr(ADDR_CFG, 32'h0000_0306);
      pulse(1'b1, 1);
      rd(ADDR_STATUS, rv);
      chk("watchdog after tick", 32'h0000_0002, {24'h00_0000, rv[23:16]});
      wr(ADDR_LIMITS, 32'h0000_FF40);
      rd(ADDR_STATUS, rv);
      chk("watchdog reloaded", 32'h0000_0003, {24'h00_0000, rv[23:16]});
      t0 = to_cnt;
      pulse(1'b1, 3);
      settle();
      chk("timeout pulse cycles", 32'h0000_0001, 32'(to_cnt - t0));
      rd(ADDR_CFG, rv);
      chk("forced control", 32'h0000_0003, {30'h0000_0000, rv[1:0]});
      chk_pin("forced on pin", 1'b1, pwm_out);
      wr(ADDR_CFG, 32'h0000_0006);
      t0 = to_cnt;
      pulse(1'b1, 3);
      settle();
      chk("disabled watchdog", 32'h0000_0000, 32'(to_cnt - t0));
      // Breathing between 0 and 3 with unequal holds at the two ends.
      wr(ADDR_CFG, 32'h0000_0080);
      wr(ADDR_LIMITS, 32'h0000_0300);
      wr(ADDR_STEP, 32'h0001_0201);
      wr(ADDR_CFG, 32'h0000_0001);
      prev = 0;
      seen = 0;
      for (int k = 0; k < 300 && seen < 5; k++) begin
         pulse(1'b0, 16);
         rd(ADDR_STATUS, rv);
         st = int'(rv[25:24]);
         if (st != prev) begin
            chk("breath phase order", 32'((prev + 1) % 4), 32'(st));
            seen++;
            prev = st;
         end
         if (st == 1) chk("breath peak duty", 32'h0000_0003, {24'h00_0000, rv[7:0]});
      end
      chk("breath phases seen", 32'h0000_0001, 32'(seen >= 5));
      print_verdict();
   end
endmodule
